//--- rtl/brs_consts.svh
// Constants of the brown-out and start-up reset sequencer: offsets, fields, timing.
// Assumes an includer that compiles with SystemVerilog and a 200 MHz aclk.
// Summary of operation
// - The brown-out enable fuse gates brown-out detection; when it is clear brown-outs never reset.
// - With detection on, a supply dip below threshold lasting the qualifying time resets the chip.
// - After any reset source, with detection on, internal reset stays asserted while the supply is below threshold.
// - Once the supply recovers, the start-up delay timer, if enabled, holds reset 72 ms more.
// - With the active-low delay enable fuse set, a brown-out reset does not run the 72 ms delay.
// - A supply drop during the delay returns to brown-out hold and restarts the full 72 ms later.
// - On power-up the delay starts after the power-on pulse, then oscillator settling, then release.
// - External clock mode with the delay disabled gives no start-up delay at all.
// - Delays run from the power-on pulse regardless of the pin; a late pin release starts at once.
// - The power-on flag reads 0 after a power-on reset, is kept by other resets, software sets it.
// - The brown-out flag is cleared by a brown-out reset after software has set it.
`ifndef BRS_CONSTS_SVH
`define BRS_CONSTS_SVH

`define BRS_CLK_MHZ 200
`define BRS_STARTUP_DELAY_MS 72
`define BRS_STARTUP_CYCLES (`BRS_STARTUP_DELAY_MS * `BRS_CLK_MHZ * 1000)
`define BRS_BOD_MIN_NS 100
`define BRS_BOD_QUAL_CYCLES ((`BRS_BOD_MIN_NS * `BRS_CLK_MHZ + 999) / 1000)
`define BRS_OSC_SETTLE_CYCLES 1024
`define BRS_TMR_W 24

`define BRS_ADDR_W 8
`define BRS_OFF_FLAGS 8'h00
`define BRS_OFF_STATE 8'h04
`define BRS_OFF_EVENT 8'h08
`define BRS_OFF_MASK 8'h0C

`define BRS_FLAG_BOD 0
`define BRS_FLAG_POR 1
`define BRS_EV_W 4
`define BRS_EV_BROWNOUT 0
`define BRS_EV_WATCHDOG 1
`define BRS_EV_POWERON 2
`define BRS_EV_RELEASE 3

`define BRS_RESP_OKAY 2'b00
`define BRS_RESP_SLVERR 2'b10
`define BRS_ZERO32 32'h0000_0000

`endif

//--- rtl/brs_pkg.sv
// Types shared by the reset sequencer modules.
// Assumes brs_consts.svh is on the include path.
`include "brs_consts.svh"
package brs_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_BROWNOUT = 3'h1,
        ST_STARTUP = 3'h3,
        ST_OSC = 3'h2,
        ST_RUN = 3'h6
    } brs_state_t;
    typedef logic [`BRS_TMR_W-1:0] brs_count_t;
endpackage

//--- rtl/brs_tmr_if.sv
// Control and completion signals between the sequencer and one of its timers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface brs_tmr_if;
    logic clear;
    logic run;
    logic done;
    modport ctl (output clear, output run, input done);
    modport tmr (input clear, input run, output done);
endinterface
`default_nettype wire

//--- rtl/brs_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the levels change slowly compared with aclk.
`timescale 1ns/1ps
`default_nettype none
module brs_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= RST;
            q_reg <= RST;
        end else if (clk_en) begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

//--- rtl/brs_timer.sv
// Saturating cycle counter: counts while run is high, clears on clear, done at LIMIT.
// Assumes LIMIT is at least one.
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.svh"
module brs_timer import brs_pkg::*; #(
    parameter brs_count_t LIMIT = 24'h00_0001
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    brs_tmr_if.tmr t
);
    brs_count_t count_reg;
    brs_count_t count_next;

    always_comb begin
        count_next = count_reg;
        if (t.clear) begin
            count_next = '0;
        end else if (t.run && count_reg != LIMIT) begin
            count_next = count_reg + 24'h00_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end

    assign t.done = (count_reg == LIMIT);
endmodule
`default_nettype wire

//--- rtl/brs_top.sv
// Brown-out, power-on and pin reset sequencer with an AXI4-Lite status port.
// Assumes supply monitor, power-on pulse, pin and fuses are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.svh"
module brs_top import brs_pkg::*; #(
    parameter int unsigned STARTUP_CYCLES = `BRS_STARTUP_CYCLES,
    parameter int unsigned OSC_SETTLE_CYCLES = `BRS_OSC_SETTLE_CYCLES,
    parameter int unsigned BOD_QUAL_CYCLES = `BRS_BOD_QUAL_CYCLES
) (
    // Clock, reset and freeze.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Supply monitor and reset sources.
    input wire logic por_pulse,
    input wire logic brownout_detect,
    input wire logic watchdog_timer,
    input wire logic external_reset_pin_n,
    // Configuration fuses.
    input wire logic brownout_enable_fuse,
    input wire logic startup_delay_enable_n,
    input wire logic external_clock_mode,
    // Internal reset and interrupt.
    output logic chip_reset_n,
    output logic irq,
    // AXI4-Lite slave.
    input wire logic [`BRS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`BRS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Synchronised pin-side levels.
    logic [5:0] raw_in;
    logic [5:0] sync_out;
    logic por_s;
    logic bod_low_s;
    logic pin_s;
    logic bod_en_s;
    logic delay_off_s;
    logic ext_clk_s;

    assign raw_in = {external_clock_mode, startup_delay_enable_n, brownout_enable_fuse,
                     external_reset_pin_n, brownout_detect, por_pulse};

    brs_sync #(.W(6), .RST(6'h01)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .d(raw_in),
        .q(sync_out)
    );

    assign por_s = sync_out[0];
    assign bod_low_s = sync_out[1];
    assign pin_s = sync_out[2];
    assign bod_en_s = sync_out[3];
    assign delay_off_s = sync_out[4];
    assign ext_clk_s = sync_out[5];

    // Timers: brown-out qualification, start-up delay, oscillator settling.
    brs_tmr_if qual_if ();
    brs_tmr_if start_if ();
    brs_tmr_if osc_if ();

    brs_timer #(.LIMIT(`BRS_TMR_W'(BOD_QUAL_CYCLES))) u_qual (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .t(qual_if.tmr)
    );

    brs_timer #(.LIMIT(`BRS_TMR_W'(STARTUP_CYCLES))) u_start (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .t(start_if.tmr)
    );

    brs_timer #(.LIMIT(`BRS_TMR_W'(OSC_SETTLE_CYCLES))) u_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .t(osc_if.tmr)
    );

    // Sequencer state.
    brs_state_t state_reg;
    brs_state_t state_next;
    logic chip_reset_n_reg;
    logic chip_reset_n_next;
    logic bod_armed;
    logic bod_event;
    logic supply_low;

    // Detection is gated by the fuse; a dip is a reset event only once qualified, but supply_low holds or returns to brown-out at once.
    assign bod_armed = bod_en_s && bod_low_s;
    assign supply_low = bod_armed;
    assign bod_event = bod_armed && qual_if.done;

    assign qual_if.clear = !bod_armed;
    assign qual_if.run = bod_armed;
    assign start_if.clear = (state_reg != ST_STARTUP);
    assign start_if.run = (state_reg == ST_STARTUP);
    assign osc_if.clear = (state_reg != ST_OSC);
    assign osc_if.run = (state_reg == ST_OSC);

    always_comb begin
        state_next = state_reg;
        if (por_s) begin
            state_next = ST_POR;
        end else if (bod_event || watchdog_timer) begin
            state_next = ST_BROWNOUT;
        end else begin
            unique case (state_reg)
                ST_POR: begin
                    state_next = ST_BROWNOUT;
                end
                ST_BROWNOUT: begin
                    if (!supply_low) begin
                        if (!delay_off_s) begin
                            state_next = ST_STARTUP;
                        end else if (ext_clk_s) begin
                            state_next = ST_RUN;
                        end else begin
                            state_next = ST_OSC;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (supply_low) begin
                        state_next = ST_BROWNOUT;
                    end else if (start_if.done) begin
                        state_next = ext_clk_s ? ST_RUN : ST_OSC;
                    end
                end
                ST_OSC: begin
                    if (supply_low) begin
                        state_next = ST_BROWNOUT;
                    end else if (osc_if.done) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_next = ST_RUN;
                end
                default: begin
                    state_next = ST_POR;
                end
            endcase
        end
        // The sequence runs on its own; the pin only gates the final release.
        chip_reset_n_next = (state_next == ST_RUN) && pin_s;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_POR;
            chip_reset_n_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            chip_reset_n_reg <= chip_reset_n_next;
        end
    end

    // Status flags, event bits, mask and interrupt.
    logic por_flag_reg;
    logic por_flag_next;
    logic bod_flag_reg;
    logic bod_flag_next;
    logic [`BRS_EV_W-1:0] event_reg;
    logic [`BRS_EV_W-1:0] event_next;
    logic [`BRS_EV_W-1:0] event_set;
    logic [`BRS_EV_W-1:0] mask_reg;
    logic [`BRS_EV_W-1:0] mask_next;
    logic irq_reg;
    logic irq_next;

    // AXI4-Lite channel state.
    logic aw_got_reg;
    logic aw_got_next;
    logic w_got_reg;
    logic w_got_next;
    logic [`BRS_ADDR_W-1:0] waddr_reg;
    logic [`BRS_ADDR_W-1:0] waddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic wlane_reg;
    logic wlane_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic do_write;
    logic wr_hit;

    assign event_set[`BRS_EV_BROWNOUT] = bod_event;
    assign event_set[`BRS_EV_WATCHDOG] = watchdog_timer;
    assign event_set[`BRS_EV_POWERON] = por_s && (state_reg != ST_POR);
    assign event_set[`BRS_EV_RELEASE] = (state_next == ST_RUN) && (state_reg != ST_RUN);

    assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

    always_comb begin
        wr_hit = 1'b1;
        por_flag_next = por_flag_reg;
        bod_flag_next = bod_flag_reg;
        event_next = event_reg;
        mask_next = mask_reg;
        if (do_write && wlane_reg) begin
            unique case (waddr_reg)
                `BRS_OFF_FLAGS: begin
                    por_flag_next = wdata_reg[`BRS_FLAG_POR];
                    bod_flag_next = wdata_reg[`BRS_FLAG_BOD];
                end
                `BRS_OFF_EVENT: begin
                    event_next = event_reg & ~wdata_reg[`BRS_EV_W-1:0];
                end
                `BRS_OFF_MASK: begin
                    mask_next = wdata_reg[`BRS_EV_W-1:0];
                end
                `BRS_OFF_STATE: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
        end else if (do_write) begin
            wr_hit = (waddr_reg == `BRS_OFF_FLAGS) || (waddr_reg == `BRS_OFF_STATE) ||
                     (waddr_reg == `BRS_OFF_EVENT) || (waddr_reg == `BRS_OFF_MASK);
        end
        // Hardware updates take priority over a software write in the same cycle.
        if (por_s) begin
            por_flag_next = 1'b0;
        end
        if (bod_event) begin
            bod_flag_next = 1'b0;
        end
        event_next = event_next | event_set;
        irq_next = |(event_next & mask_next);
    end

    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wlane_next = wlane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_got_next = 1'b1;
            waddr_next = {s_axi_awaddr[`BRS_ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && wready_reg) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wlane_next = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? `BRS_RESP_OKAY : `BRS_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_got_next && !bvalid_next;
        wready_next = !w_got_next && !bvalid_next;
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `BRS_RESP_OKAY;
            rdata_next = `BRS_ZERO32;
            unique case ({s_axi_araddr[`BRS_ADDR_W-1:2], 2'b00})
                `BRS_OFF_FLAGS: begin
                    rdata_next[`BRS_FLAG_POR] = por_flag_reg;
                    rdata_next[`BRS_FLAG_BOD] = bod_flag_reg;
                end
                `BRS_OFF_STATE: begin
                    rdata_next[2:0] = state_reg;
                    rdata_next[3] = chip_reset_n_reg;
                    rdata_next[4] = pin_s;
                    rdata_next[5] = bod_low_s;
                end
                `BRS_OFF_EVENT: begin
                    rdata_next[`BRS_EV_W-1:0] = event_reg;
                end
                `BRS_OFF_MASK: begin
                    rdata_next[`BRS_EV_W-1:0] = mask_reg;
                end
                default: begin
                    rresp_next = `BRS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_flag_reg <= 1'b0;
            bod_flag_reg <= 1'b0;
            event_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= `BRS_ZERO32;
            wlane_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `BRS_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= `BRS_RESP_OKAY;
            rdata_reg <= `BRS_ZERO32;
        end else if (clk_en) begin
            por_flag_reg <= por_flag_next;
            bod_flag_reg <= bod_flag_next;
            event_reg <= event_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wlane_reg <= wlane_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign chip_reset_n = chip_reset_n_reg;
    assign irq = irq_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
endmodule
`default_nettype wire

//--- tb/brs_monitor.sv
// Port checks of the reset sequencer, bound into brs_top.
// Assumes one aclk domain and the small timer counts that the bench uses.
`timescale 1ns/1ps
`default_nettype none
module brs_monitor #(
    parameter int unsigned STARTUP_CYCLES = 20,
    parameter int unsigned OSC_SETTLE_CYCLES = 8,
    parameter int unsigned BOD_QUAL_CYCLES = 3
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Reset sources, fuses and internal reset.
    input wire logic por_pulse,
    input wire logic brownout_detect,
    input wire logic watchdog_timer,
    input wire logic external_reset_pin_n,
    input wire logic brownout_enable_fuse,
    input wire logic startup_delay_enable_n,
    input wire logic external_clock_mode,
    input wire logic chip_reset_n,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Cycles since the last reset source, and cycles of unbroken low supply.
    logic [31:0] quiet_reg, quiet_next, low_reg, low_next;
    always_comb begin
        quiet_next = quiet_reg;
        low_next = 32'h0000_0000;
        if (brownout_enable_fuse && brownout_detect) begin
            low_next = low_reg + 32'h0000_0001;
        end
        if (por_pulse || watchdog_timer || low_next != 32'h0000_0000) begin
            quiet_next = 32'h0000_0000;
        end else if (quiet_reg != 32'hffff_ffff) begin
            quiet_next = quiet_reg + 32'h0000_0001;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quiet_reg <= 32'h0000_0000;
            low_reg <= 32'h0000_0000;
        end else begin
            quiet_reg <= quiet_next;
            low_reg <= low_next;
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pin_held;
        (!external_reset_pin_n)[*4];
    endsequence
    a_supply_hold: assert property (low_reg > BOD_QUAL_CYCLES + 5 |-> !chip_reset_n)
        else $error("internal reset released during a qualified brown-out");
    a_pin_hold: assert property (s_pin_held |=> !chip_reset_n)
        else $error("internal reset released while the pin is low");
    a_por_hold: assert property (por_pulse[*4] |=> !chip_reset_n)
        else $error("internal reset released during the power-on pulse");
    a_startup_len: assert property ($rose(chip_reset_n) && !startup_delay_enable_n |-> quiet_reg >= STARTUP_CYCLES)
        else $error("release came before the full start-up delay");
    a_no_delay: assert property ($fell(por_pulse) && external_clock_mode && startup_delay_enable_n
        && external_reset_pin_n |-> ##[1:8] chip_reset_n)
        else $error("start-up delay applied with no delay configured");
    a_pin_release: assert property ($rose(external_reset_pin_n)
        && quiet_reg > STARTUP_CYCLES + OSC_SETTLE_CYCLES + 8 |-> ##[2:4] chip_reset_n)
        else $error("late pin release did not start execution at once");
    a_fuse_gates: assert property ((chip_reset_n && !brownout_enable_fuse && !por_pulse
        && !watchdog_timer && external_reset_pin_n)[*4] |=> chip_reset_n)
        else $error("reset taken with brown-out detection disabled");
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before rready");
endmodule
bind brs_top brs_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES), .OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES),
    .BOD_QUAL_CYCLES(BOD_QUAL_CYCLES)) i_mon (.*);
`default_nettype wire

//--- tb/brs_top_tb_top.sv
// Self-checking bench of the reset sequencer: register rows, then reset scenarios.
// Assumes brs_monitor is bound in and the design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            fails++; \
            $display("mismatch %s exp %h got %h", nm, ex, got); \
        end \
    end
module brs_top_tb_top;
    localparam int unsigned ST = 20;
    localparam int unsigned OS = 8;
    localparam int unsigned BQ = 3;
    typedef struct packed {
        logic wr, q;
        logic [7:0] a, d, x;
        logic [3:0] s;
        logic [1:0] r;
    } brs_row_t;
    // Write or read, irq after, address, data, read value, strobe, response.
    brs_row_t rows [12] = '{
        '{1'h0, 1'h0, 8'h08, 8'h00, 8'h08, 4'hf, 2'h0},
        '{1'h1, 1'h1, 8'h0c, 8'h08, 8'h00, 4'hf, 2'h0},
        '{1'h1, 1'h1, 8'h0c, 8'h00, 8'h00, 4'h0, 2'h0},
        '{1'h0, 1'h1, 8'h0c, 8'h00, 8'h08, 4'hf, 2'h0},
        '{1'h1, 1'h0, 8'h08, 8'h08, 8'h00, 4'hf, 2'h0},
        '{1'h0, 1'h0, 8'h08, 8'h00, 8'h00, 4'hf, 2'h0},
        '{1'h1, 1'h0, 8'h00, 8'h03, 8'h00, 4'hf, 2'h0},
        '{1'h0, 1'h0, 8'h00, 8'h00, 8'h03, 4'hf, 2'h0},
        '{1'h0, 1'h0, 8'h04, 8'h00, 8'h1e, 4'hf, 2'h0},
        '{1'h1, 1'h0, 8'h10, 8'h01, 8'h00, 4'hf, 2'h2},
        '{1'h0, 1'h0, 8'h10, 8'h00, 8'h00, 4'hf, 2'h2},
        '{1'h1, 1'h0, 8'h0c, 8'h0f, 8'h00, 4'hf, 2'h0}
    };
    logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, por_pulse = 1'h1, watchdog_timer = 1'h0;
    logic brownout_detect = 1'h0, external_reset_pin_n = 1'h1, brownout_enable_fuse = 1'h1;
    logic startup_delay_enable_n = 1'h0, external_clock_mode = 1'h0, chip_reset_n, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int fails = 0, n_tests = 0, cyc_cnt = 0, n;
    brs_top #(.STARTUP_CYCLES(ST), .OSC_SETTLE_CYCLES(OS), .BOD_QUAL_CYCLES(BQ)) i_dut (.*);
    always #2.5 aclk = ~aclk;
    task automatic close_out();
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc_cnt++;
        if (cyc_cnt == 2000) begin
            fails++;
            close_out();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic wait_rel(output int k);
        k = 0;
        while (chip_reset_n !== 1'h1) begin
            @(posedge aclk);
            k++;
        end
    endtask
    initial begin
        tick(3);
        `CHK("reset", 1'h0, chip_reset_n)
        aresetn <= 1'h1;
        tick(2);
        por_pulse <= 1'h0;
        wait_rel(n);
        `CHK("powerup", 1'h1, n >= ST + OS && n <= ST + OS + 10)
        for (int i = 0; i < 12; i++) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d, rows[i].s, rs);
            end else begin
                rd_reg(rows[i].a, rd, rs);
                `CHK("rdata", {24'h00_0000, rows[i].x}, rd)
            end
            `CHK("resp", rows[i].r, rs)
            tick(2);
            `CHK("irq", rows[i].q, irq)
        end
        brownout_detect <= 1'h1;
        tick(2);
        brownout_detect <= 1'h0;
        tick(10);
        `CHK("short dip", 1'h1, chip_reset_n)
        brownout_detect <= 1'h1;
        tick(20);
        `CHK("held low", 1'h0, chip_reset_n)
        `CHK("irq bod", 1'h1, irq)
        brownout_detect <= 1'h0;
        tick(10);
        brownout_detect <= 1'h1;
        tick(10);
        brownout_detect <= 1'h0;
        wait_rel(n);
        `CHK("restart", 1'h1, n >= ST + OS && n <= ST + OS + 10)
        rd_reg(8'h00, rd, rs);
        `CHK("flags bod", 32'h0000_0002, rd)
        wr(8'h08, 8'h0f, 4'hf, rs);
        startup_delay_enable_n <= 1'h1;
        tick(3);
        watchdog_timer <= 1'h1;
        tick(1);
        watchdog_timer <= 1'h0;
        tick(3);
        wait_rel(n);
        `CHK("no delay", 1'h1, n < ST)
        rd_reg(8'h08, rd, rs);
        `CHK("events wdt", 32'h0000_000a, rd)
        brownout_enable_fuse <= 1'h0;
        tick(3);
        brownout_detect <= 1'h1;
        tick(20);
        `CHK("fuse off", 1'h1, chip_reset_n)
        brownout_detect <= 1'h0;
        brownout_enable_fuse <= 1'h1;
        external_clock_mode <= 1'h1;
        tick(3);
        por_pulse <= 1'h1;
        tick(5);
        por_pulse <= 1'h0;
        wait_rel(n);
        `CHK("ext clock", 1'h1, n <= 8)
        rd_reg(8'h00, rd, rs);
        `CHK("flags por", 32'h0000_0000, rd)
        external_clock_mode <= 1'h0;
        startup_delay_enable_n <= 1'h0;
        external_reset_pin_n <= 1'h0;
        por_pulse <= 1'h1;
        tick(5);
        por_pulse <= 1'h0;
        tick(ST + OS + 20);
        `CHK("pin held", 1'h0, chip_reset_n)
        external_reset_pin_n <= 1'h1;
        wait_rel(n);
        `CHK("pin late", 1'h1, n <= 5)
        aresetn <= 1'h0;
        tick(3);
        `CHK("rst chip", 1'h0, chip_reset_n)
        `CHK("rst irq", 1'h0, irq)
        aresetn <= 1'h1;
        rd_reg(8'h0c, rd, rs);
        `CHK("rst mask", 32'h0000_0000, rd)
        close_out();
    end
endmodule
`default_nettype wire
